//--- pkg/cpu8_pkg.sv
// constants, types and register map of the 8-bit cpu opcode and bus-cycle decoder
// Overview of operation
// - a free cycle takes exactly one clock
// - a free cycle is always presented as a read
// - a program fetch reads the next sequential program address
// - vector cycles read the top page, high byte before low byte
// - a push cycle writes one byte onto the stack
// - a pop cycle reads one byte from the stack
// - an operand read moves one byte from memory to the core
// - an operand write moves one byte from the core to memory
// - flag register holds overflow, half-carry, mask, negative, zero, carry
// - indexed no-offset post-increment mode (cbeq) bumps the index register after access
// - indexed mode adds an unsigned byte offset to the index register
// - indexed mode adds a 16-bit offset to the index register
// - stack mode adds a byte offset to the stack pointer
// - stack mode adds a 16-bit offset to the stack pointer
// - operand fields are zero, one or two bytes, set by addressing mode
// - relative branches carry one offset byte added to the program counter
// - negation and subtraction use two's complement
package cpu8_pkg;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_SP = 8'h0C;
  localparam logic [7:0] OFS_HX = 8'h10;
  localparam logic [7:0] OFS_ACC = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_OPCODE = 8'h1C;

  localparam int CTRL_STEP_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_VEC_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ILL_BIT = 1;
  localparam int ST_LEN_LSB = 8;
  localparam int ST_CYC_LSB = 12;
  localparam int ST_MODE_LSB = 16;
  localparam int OPC_PAGE2_BIT = 8;

  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_V = 7;
  localparam logic [7:0] FLG_ONES = 8'h60;

  localparam logic [7:0] PAGE2_PREFIX = 8'h9E;
  localparam logic [7:0] VEC_PAGE = 8'hFF;
  localparam logic [7:0] SWI_VEC_LO = 8'hFC;
  localparam logic [7:0] RST_VEC_LO = 8'hFE;
  localparam logic [3:0] MEM_GRP_FIRST = 4'hA;

  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [15:0] HX_RST = 16'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h68;

  localparam int SEQ_MAX = 8;

  typedef enum logic [2:0] {
    CYC_FREE, CYC_PROG, CYC_READ, CYC_WRITE, CYC_PUSH, CYC_POP, CYC_VEC
  } cyc_t;

  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX, MODE_IDX8, MODE_IDX16,
    MODE_IXP, MODE_STK8, MODE_STK16, MODE_REL
  } mode_t;

  typedef enum logic [3:0] {
    ALU_SUB, ALU_CMP, ALU_SBC, ALU_AND, ALU_BIT, ALU_LDA, ALU_EOR, ALU_ADC,
    ALU_ORA, ALU_ADD, ALU_NEG
  } alu_op_t;

  typedef enum logic [3:0] {
    INH_NONE, INH_TAP, INH_TPA, INH_TAX, INH_TXA, INH_CLC, INH_SEC, INH_CLI,
    INH_SEI, INH_SWI, INH_BR, INH_CBEQ
  } inh_t;

  typedef enum logic [2:0] {SRC_PCL, SRC_PCH, SRC_X, SRC_A, SRC_FLG} src_t;

  typedef struct packed {
    mode_t mode;
    alu_op_t op;
    inh_t inh;
    src_t push_src;
    logic alu_en;
    logic acc_wr;
    logic pop_x;
    logic illegal;
    logic [1:0] opnd_len;
    logic [2:0] length;
    logic [3:0] cycles;
    logic [3:0] seq_len;
    cyc_t [SEQ_MAX-1:0] seq;
  } dec_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic active;
    cyc_t cyc;
  } bus_req_t;

endpackage

//--- logic/cpu8_alu.sv
// 8-bit arithmetic and logic unit with flag update
`timescale 1ns/10ps
module cpu8_alu (
  input wire logic [7:0] A_I, // accumulator operand
  input wire logic [7:0] B_I, // memory, immediate or accumulator operand
  input wire logic [7:0] FLAGS_I, // current flags
  input cpu8_pkg::alu_op_t OP_I, // operation
  output logic [7:0] RES_O, // result
  output logic [7:0] FLAGS_O // updated flags
);
  import cpu8_pkg::*;
  logic [8:0] sum;
  logic [7:0] opa;
  logic [7:0] logic_r;
  logic is_add;
  logic is_sub;
  assign opa = (OP_I == ALU_NEG) ? 8'h00 : A_I;
  assign is_add = (OP_I == ALU_ADD) || (OP_I == ALU_ADC);
  assign is_sub = (OP_I == ALU_SUB) || (OP_I == ALU_CMP) || (OP_I == ALU_SBC) ||
                  (OP_I == ALU_NEG);
  always_comb begin
    sum = 9'h000;
    logic_r = 8'h00;
    unique case (OP_I)
      ALU_ADD: sum = {1'b0, A_I} + {1'b0, B_I};
      ALU_ADC: sum = {1'b0, A_I} + {1'b0, B_I} + {8'h00, FLAGS_I[FLG_C]};
      ALU_SBC: sum = {1'b0, A_I} - {1'b0, B_I} - {8'h00, FLAGS_I[FLG_C]};
      ALU_SUB, ALU_CMP, ALU_NEG: sum = {1'b0, opa} - {1'b0, B_I};
      ALU_AND, ALU_BIT: logic_r = A_I & B_I;
      ALU_EOR: logic_r = A_I ^ B_I;
      ALU_ORA: logic_r = A_I | B_I;
      default: logic_r = B_I;
    endcase
  end
  assign RES_O = (is_add || is_sub) ? sum[7:0] : logic_r;
  always_comb begin
    FLAGS_O = FLAGS_I | FLG_ONES;
    FLAGS_O[FLG_N] = RES_O[7];
    FLAGS_O[FLG_Z] = (RES_O == 8'h00);
    FLAGS_O[FLG_V] = 1'b0;
    if (is_add) begin
      FLAGS_O[FLG_V] = (A_I[7] & B_I[7] & ~RES_O[7]) | (~A_I[7] & ~B_I[7] & RES_O[7]);
      FLAGS_O[FLG_H] = (A_I[3] & B_I[3]) | (B_I[3] & ~RES_O[3]) | (~RES_O[3] & A_I[3]);
      FLAGS_O[FLG_C] = sum[8];
    end else if (is_sub) begin
      // borrow out of bit 7 is the carry flag after a subtract
      FLAGS_O[FLG_V] = (opa[7] & ~B_I[7] & ~RES_O[7]) | (~opa[7] & B_I[7] & RES_O[7]);
      FLAGS_O[FLG_C] = sum[8];
    end
  end
endmodule

//--- logic/cpu8_opcode_decode.sv
// opcode to addressing mode, length, cycle count and bus-cycle sequence
`timescale 1ns/10ps
module cpu8_opcode_decode (
  input wire logic [7:0] OPCODE_I, // opcode byte
  input wire logic PAGE2_I, // second-page prefix seen
  output cpu8_pkg::dec_t DEC_O // decoded instruction
);
  import cpu8_pkg::*;
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = OPCODE_I[7:4];
  assign lo = OPCODE_I[3:0];
  always_comb begin
    DEC_O = '0;
    DEC_O.seq_len = 4'h1;
    if (hi >= MEM_GRP_FIRST) begin
      unique case (hi)
        4'hA: DEC_O.mode = MODE_IMM;
        4'hB: DEC_O.mode = MODE_DIR;
        4'hC: DEC_O.mode = MODE_EXT;
        4'hD: DEC_O.mode = PAGE2_I ? MODE_STK16 : MODE_IDX16;
        4'hE: DEC_O.mode = PAGE2_I ? MODE_STK8 : MODE_IDX8;
        default: DEC_O.mode = MODE_IX;
      endcase
      DEC_O.illegal = PAGE2_I && (hi != 4'hD) && (hi != 4'hE);
      DEC_O.alu_en = 1'b1;
      DEC_O.acc_wr = 1'b1;
      unique case (lo)
        4'h0: DEC_O.op = ALU_SUB;
        4'h1: begin DEC_O.op = ALU_CMP; DEC_O.acc_wr = 1'b0; end
        4'h2: DEC_O.op = ALU_SBC;
        4'h4: DEC_O.op = ALU_AND;
        4'h5: begin DEC_O.op = ALU_BIT; DEC_O.acc_wr = 1'b0; end
        4'h6: DEC_O.op = ALU_LDA;
        4'h8: DEC_O.op = ALU_EOR;
        4'h9: DEC_O.op = ALU_ADC;
        4'hA: DEC_O.op = ALU_ORA;
        4'hB: DEC_O.op = ALU_ADD;
        4'h7: begin
          DEC_O.alu_en = 1'b0;
          DEC_O.acc_wr = 1'b0;
          DEC_O.illegal = DEC_O.illegal || (hi == 4'hA);
        end
        default: begin DEC_O.illegal = 1'b1; DEC_O.alu_en = 1'b0; DEC_O.acc_wr = 1'b0; end
      endcase
      if (lo == 4'h7) DEC_O.seq[0] = CYC_WRITE;
      else if (DEC_O.mode != MODE_IMM) DEC_O.seq[0] = CYC_READ;
      unique case (DEC_O.mode)
        MODE_EXT, MODE_IDX16, MODE_STK16: DEC_O.opnd_len = 2'h2;
        MODE_IX: DEC_O.opnd_len = 2'h0;
        default: DEC_O.opnd_len = 2'h1;
      endcase
    end else if (!PAGE2_I && (hi == 4'h2)) begin
      DEC_O.mode = MODE_REL;
      DEC_O.inh = INH_BR;
      DEC_O.opnd_len = 2'h1;
      DEC_O.illegal = !(lo inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB});
    end else if (!PAGE2_I) begin
      unique case (OPCODE_I)
        8'h40: begin DEC_O.op = ALU_NEG; DEC_O.alu_en = 1'b1; DEC_O.acc_wr = 1'b1; end
        8'h71: begin
          DEC_O.mode = MODE_IXP;
          DEC_O.inh = INH_CBEQ;
          DEC_O.opnd_len = 2'h1;
          DEC_O.seq[0] = CYC_READ;
          DEC_O.seq_len = 4'h2;
        end
        8'h83: begin
          for (int i = 0; i < 5; i++) DEC_O.seq[i] = CYC_PUSH;
          DEC_O.seq[5] = CYC_VEC;
          DEC_O.seq[6] = CYC_VEC;
          DEC_O.seq_len = 4'h8;
          DEC_O.inh = INH_SWI;
        end
        8'h84: DEC_O.inh = INH_TAP;
        8'h85: DEC_O.inh = INH_TPA;
        8'h97: DEC_O.inh = INH_TAX;
        8'h9F: DEC_O.inh = INH_TXA;
        8'h98: DEC_O.inh = INH_CLC;
        8'h99: DEC_O.inh = INH_SEC;
        8'h9A: DEC_O.inh = INH_CLI;
        8'h9B: DEC_O.inh = INH_SEI;
        8'h9D: DEC_O.inh = INH_NONE;
        8'h87: begin DEC_O.seq[0] = CYC_PUSH; DEC_O.push_src = SRC_A; end
        8'h89: begin DEC_O.seq[0] = CYC_PUSH; DEC_O.push_src = SRC_X; end
        8'h86: DEC_O.seq[0] = CYC_POP;
        8'h88: begin DEC_O.seq[0] = CYC_POP; DEC_O.pop_x = 1'b1; end
        default: DEC_O.illegal = 1'b1;
      endcase
    end else begin
      DEC_O.illegal = 1'b1;
    end
    DEC_O.length = 3'h1 + {2'h0, PAGE2_I} + {1'b0, DEC_O.opnd_len};
    DEC_O.cycles = {1'b0, DEC_O.length} + 4'h1 + DEC_O.seq_len;
  end
endmodule

//--- logic/cpu8_opcode_bus_cycle_decoder.sv
// instruction decoder and bus-cycle sequencer of an 8-bit accumulator core
`timescale 1ns/10ps
module cpu8_opcode_bus_cycle_decoder (
  input wire logic CLK_I, // system bus clock, 40 MHz
  input wire logic RESETN_I, // synchronous reset, active low
  input cpu8_pkg::apb_req_t APB_I, // apb request signals
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error, unmapped address
  output cpu8_pkg::bus_req_t MEM_REQ_O, // memory bus cycle
  input wire logic [7:0] MEM_RDATA_I, // memory read data
  output cpu8_pkg::dec_t DEC_O // decode of current instruction
);
  import cpu8_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_DEC = 3'b011,
    ST_OPND = 3'b010,
    ST_EXEC = 3'b110
  } state_t;

  state_t state_ff, nxt_state;
  logic [2:0] step_ff, nxt_step;
  logic [7:0] opc_ff, nxt_opc;
  logic page2_ff, nxt_page2;
  logic [15:0] opnd_ff, nxt_opnd;
  logic [1:0] cnt_ff, nxt_cnt;
  dec_t dec_ff, nxt_dec;
  logic [15:0] pc_ff, nxt_pc;
  logic [15:0] sp_ff, nxt_sp;
  logic [15:0] hx_ff, nxt_hx;
  logic [7:0] acc_ff, nxt_acc;
  logic [7:0] flags_ff, nxt_flags;
  logic run_ff, nxt_run;
  logic illegal_ff, nxt_illegal;
  logic vsel_ff, nxt_vsel;
  logic [7:0] veclo_ff, nxt_veclo;
  logic eq_ff, nxt_eq;
  bus_req_t req_ff, nxt_req;
  logic [31:0] prdata_ff, nxt_prdata;

  dec_t dec_w;
  dec_t vec_dec_w;
  cyc_t cur_cyc;
  cyc_t nxt_cyc;
  src_t psrc;
  logic last_step;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic br_take;
  logic [15:0] rel_ofs;
  logic [15:0] ea_w;
  logic [15:0] ofs8_w;
  logic [7:0] push_data;

  logic apb_wr;
  logic apb_setup_rd;
  logic hit_ctrl, hit_status, hit_pc, hit_sp, hit_hx, hit_acc, hit_flags, hit_opc;
  logic mapped;
  logic idle_w;
  logic start_w;
  logic vec_start_w;
  logic [31:0] rd_mux;

  cpu8_opcode_decode u_decode (
    .OPCODE_I(opc_ff),
    .PAGE2_I(page2_ff),
    .DEC_O(dec_w)
  );

  cpu8_alu u_alu (
    .A_I(acc_ff),
    .B_I(alu_b),
    .FLAGS_I(flags_ff),
    .OP_I(dec_ff.op),
    .RES_O(alu_res),
    .FLAGS_O(alu_flags)
  );

  // register bus decode; every access completes in its first access cycle
  assign apb_wr = APB_I.psel & APB_I.penable & APB_I.pwrite;
  assign apb_setup_rd = APB_I.psel & ~APB_I.penable & ~APB_I.pwrite;
  assign hit_ctrl = (APB_I.paddr == OFS_CTRL);
  assign hit_status = (APB_I.paddr == OFS_STATUS);
  assign hit_pc = (APB_I.paddr == OFS_PC);
  assign hit_sp = (APB_I.paddr == OFS_SP);
  assign hit_hx = (APB_I.paddr == OFS_HX);
  assign hit_acc = (APB_I.paddr == OFS_ACC);
  assign hit_flags = (APB_I.paddr == OFS_FLAGS);
  assign hit_opc = (APB_I.paddr == OFS_OPCODE);
  assign mapped = hit_ctrl | hit_status | hit_pc | hit_sp | hit_hx | hit_acc | hit_flags |
                  hit_opc;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = APB_I.psel & APB_I.penable & ~mapped;
  assign PRDATA_O = prdata_ff;

  assign idle_w = (state_ff == ST_IDLE);
  assign start_w = apb_wr & hit_ctrl & APB_I.pwdata[CTRL_STEP_BIT];
  assign vec_start_w = apb_wr & hit_ctrl & APB_I.pwdata[CTRL_VEC_BIT];

  assign rd_mux = hit_ctrl ? {30'h00000000, run_ff, 1'b0} :
                  hit_status ? {12'h000, dec_ff.mode, dec_ff.cycles, 1'b0, dec_ff.length,
                                6'h00, illegal_ff, ~idle_w} :
                  hit_pc ? {16'h0000, pc_ff} :
                  hit_sp ? {16'h0000, sp_ff} :
                  hit_hx ? {16'h0000, hx_ff} :
                  hit_acc ? {24'h000000, acc_ff} :
                  hit_flags ? {24'h000000, flags_ff} :
                  hit_opc ? {23'h000000, page2_ff, opc_ff} : 32'h00000000;
  assign nxt_prdata = apb_setup_rd ? rd_mux : prdata_ff;

  // reset-vector fetch uses the same engine with a fixed two-cycle sequence
  always_comb begin
    vec_dec_w = '0;
    vec_dec_w.seq[0] = CYC_VEC;
    vec_dec_w.seq[1] = CYC_VEC;
    vec_dec_w.seq_len = 4'h2;
    vec_dec_w.cycles = 4'h2;
  end

  assign cur_cyc = dec_ff.seq[step_ff];
  assign last_step = ({1'b0, step_ff} == (dec_ff.seq_len - 4'h1));
  assign alu_b = (cur_cyc == CYC_READ) ? MEM_RDATA_I :
                 (dec_ff.mode == MODE_IMM) ? opnd_ff[7:0] : acc_ff;
  assign rel_ofs = {{8{opnd_ff[7]}}, opnd_ff[7:0]};

  always_comb begin
    unique case (opc_ff[3:0])
      4'h0: br_take = 1'b1;
      4'h4: br_take = ~flags_ff[FLG_C];
      4'h5: br_take = flags_ff[FLG_C];
      4'h6: br_take = ~flags_ff[FLG_Z];
      4'h7: br_take = flags_ff[FLG_Z];
      4'hA: br_take = ~flags_ff[FLG_N];
      4'hB: br_take = flags_ff[FLG_N];
      default: br_take = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_opc = opc_ff;
    nxt_page2 = page2_ff;
    nxt_opnd = opnd_ff;
    nxt_cnt = cnt_ff;
    nxt_dec = dec_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_hx = hx_ff;
    nxt_acc = acc_ff;
    nxt_flags = flags_ff;
    nxt_run = run_ff;
    nxt_illegal = illegal_ff;
    nxt_vsel = vsel_ff;
    nxt_veclo = veclo_ff;
    nxt_eq = eq_ff;
    if (apb_wr && hit_ctrl) nxt_run = APB_I.pwdata[CTRL_RUN_BIT];
    if (apb_wr && hit_status && APB_I.pwdata[ST_ILL_BIT]) nxt_illegal = 1'b0;
    // core state is only written by software while the engine is idle
    if (apb_wr && idle_w) begin
      if (hit_pc) nxt_pc = APB_I.pwdata[15:0];
      if (hit_sp) nxt_sp = APB_I.pwdata[15:0];
      if (hit_hx) nxt_hx = APB_I.pwdata[15:0];
      if (hit_acc) nxt_acc = APB_I.pwdata[7:0];
      if (hit_flags) nxt_flags = APB_I.pwdata[7:0] | FLG_ONES;
    end
    unique case (state_ff)
      ST_IDLE: begin
        nxt_page2 = 1'b0;
        if (vec_start_w) begin
          nxt_dec = vec_dec_w;
          nxt_veclo = RST_VEC_LO;
          nxt_vsel = 1'b0;
          nxt_step = 3'h0;
          nxt_state = ST_EXEC;
        end else if (start_w || run_ff) begin
          nxt_state = ST_OPC;
        end
      end
      ST_OPC: begin
        nxt_opc = MEM_RDATA_I;
        nxt_pc = pc_ff + 16'h0001;
        nxt_state = ST_DEC;
      end
      ST_DEC: begin
        if ((opc_ff == PAGE2_PREFIX) && !page2_ff) begin
          nxt_page2 = 1'b1;
          nxt_state = ST_OPC;
        end else begin
          nxt_dec = dec_w;
          nxt_illegal = nxt_illegal | dec_w.illegal;
          nxt_step = 3'h0;
          nxt_vsel = 1'b0;
          nxt_veclo = SWI_VEC_LO;
          nxt_cnt = dec_w.opnd_len;
          nxt_state = (dec_w.opnd_len != 2'h0) ? ST_OPND : ST_EXEC;
        end
      end
      ST_OPND: begin
        // operand bytes arrive high byte first
        nxt_opnd = {opnd_ff[7:0], MEM_RDATA_I};
        nxt_pc = pc_ff + 16'h0001;
        nxt_cnt = cnt_ff - 2'h1;
        if (cnt_ff == 2'h1) nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        unique case (cur_cyc)
          CYC_PUSH: nxt_sp = sp_ff - 16'h0001;
          CYC_POP: begin
            nxt_sp = sp_ff + 16'h0001;
            if (dec_ff.pop_x) nxt_hx[7:0] = MEM_RDATA_I;
            else nxt_acc = MEM_RDATA_I;
          end
          CYC_VEC: begin
            if (!vsel_ff) nxt_pc[15:8] = MEM_RDATA_I;
            else nxt_pc[7:0] = MEM_RDATA_I;
            nxt_vsel = ~vsel_ff;
          end
          CYC_READ: begin
            nxt_eq = (acc_ff == MEM_RDATA_I);
            if (dec_ff.mode == MODE_IXP) nxt_hx = hx_ff + 16'h0001;
          end
          default: nxt_eq = eq_ff;
        endcase
        if (last_step) begin
          if (dec_ff.alu_en) nxt_flags = alu_flags;
          if (dec_ff.acc_wr) nxt_acc = alu_res;
          unique case (dec_ff.inh)
            INH_TAP: nxt_flags = acc_ff | FLG_ONES;
            INH_TPA: nxt_acc = flags_ff;
            INH_TAX: nxt_hx[7:0] = acc_ff;
            INH_TXA: nxt_acc = hx_ff[7:0];
            INH_CLC: nxt_flags[FLG_C] = 1'b0;
            INH_SEC: nxt_flags[FLG_C] = 1'b1;
            INH_CLI: nxt_flags[FLG_I] = 1'b0;
            INH_SEI, INH_SWI: nxt_flags[FLG_I] = 1'b1;
            INH_BR: if (br_take) nxt_pc = pc_ff + rel_ofs;
            INH_CBEQ: if (eq_ff) nxt_pc = pc_ff + rel_ofs;
            default: nxt_page2 = 1'b0;
          endcase
          nxt_page2 = 1'b0;
          nxt_state = nxt_run ? ST_OPC : ST_IDLE;
        end else begin
          nxt_step = step_ff + 3'h1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // effective address of the cycle about to start
  assign ofs8_w = {8'h00, nxt_opnd[7:0]};
  always_comb begin
    unique case (nxt_dec.mode)
      MODE_DIR: ea_w = ofs8_w;
      MODE_EXT: ea_w = nxt_opnd;
      MODE_IX, MODE_IXP: ea_w = hx_ff;
      MODE_IDX8: ea_w = hx_ff + ofs8_w;
      MODE_IDX16: ea_w = hx_ff + nxt_opnd;
      MODE_STK8: ea_w = sp_ff + ofs8_w;
      MODE_STK16: ea_w = sp_ff + nxt_opnd;
      default: ea_w = nxt_pc;
    endcase
  end

  assign nxt_cyc = nxt_dec.seq[nxt_step];
  assign psrc = src_t'(3'(nxt_dec.push_src) + nxt_step);
  always_comb begin
    unique case (psrc)
      SRC_PCL: push_data = pc_ff[7:0];
      SRC_PCH: push_data = pc_ff[15:8];
      SRC_X: push_data = hx_ff[7:0];
      SRC_A: push_data = acc_ff;
      default: push_data = flags_ff;
    endcase
  end

  // the bus cycle is registered; each one lasts exactly one clock
  always_comb begin
    nxt_req = '0;
    nxt_req.addr = nxt_pc;
    unique case (nxt_state)
      ST_OPC, ST_OPND: begin
        nxt_req.active = 1'b1;
        nxt_req.cyc = CYC_PROG;
      end
      ST_DEC: nxt_req.active = 1'b1;
      ST_EXEC: begin
        nxt_req.active = 1'b1;
        nxt_req.cyc = nxt_cyc;
        unique case (nxt_cyc)
          CYC_READ: nxt_req.addr = ea_w;
          CYC_WRITE: begin
            nxt_req.addr = ea_w;
            nxt_req.wdata = acc_ff;
            nxt_req.write = 1'b1;
          end
          CYC_PUSH: begin
            nxt_req.addr = nxt_sp;
            nxt_req.wdata = push_data;
            nxt_req.write = 1'b1;
          end
          CYC_POP: nxt_req.addr = nxt_sp + 16'h0001;
          CYC_VEC: nxt_req.addr = {VEC_PAGE, nxt_veclo + {7'h00, nxt_vsel}};
          default: nxt_req.write = 1'b0;
        endcase
      end
      default: nxt_req.active = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      state_ff <= ST_IDLE;
      step_ff <= 3'h0;
      opc_ff <= 8'h00;
      page2_ff <= 1'b0;
      opnd_ff <= 16'h0000;
      cnt_ff <= 2'h0;
      dec_ff <= '0;
      run_ff <= 1'b0;
      illegal_ff <= 1'b0;
      vsel_ff <= 1'b0;
      veclo_ff <= SWI_VEC_LO;
      eq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      opc_ff <= nxt_opc;
      page2_ff <= nxt_page2;
      opnd_ff <= nxt_opnd;
      cnt_ff <= nxt_cnt;
      dec_ff <= nxt_dec;
      run_ff <= nxt_run;
      illegal_ff <= nxt_illegal;
      vsel_ff <= nxt_vsel;
      veclo_ff <= nxt_veclo;
      eq_ff <= nxt_eq;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      pc_ff <= PC_RST;
      sp_ff <= SP_RST;
      hx_ff <= HX_RST;
      acc_ff <= ACC_RST;
      flags_ff <= FLAGS_RST;
      req_ff <= '0;
      prdata_ff <= 32'h00000000;
    end else begin
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      hx_ff <= nxt_hx;
      acc_ff <= nxt_acc;
      flags_ff <= nxt_flags;
      req_ff <= nxt_req;
      prdata_ff <= nxt_prdata;
    end
  end

  assign MEM_REQ_O = req_ff;
  assign DEC_O = dec_ff;
endmodule

//--- verif/cpu8_mem_model.sv
// behavioural program and data memory on the far side of the bus
`timescale 1ns/10ps
module cpu8_mem_model (
  input wire logic clk_i, // clock
  input cpu8_pkg::bus_req_t req_i, // bus cycle
  output logic [7:0] rdata_o // read data
);
  import cpu8_pkg::*;
  logic [7:0] mem [65536];
  logic [7:0] last_ff = 8'h00;
  // idle bus shows a toggling pattern so a stale sample cannot pass
  assign rdata_o = (req_i.active && !req_i.write) ? mem[req_i.addr] : ~last_ff;
  always @(posedge clk_i) begin
    last_ff <= rdata_o;
    if (req_i.active && req_i.write) mem[req_i.addr] <= req_i.wdata;
  end
endmodule

//--- verif/cpu8_decoder_chk.sv
// bus-cycle and decode checker for the cpu8 decoder
`timescale 1ns/10ps
module cpu8_decoder_chk (
  input wire logic CLK_I, // clock
  input wire logic RESETN_I, // reset
  input cpu8_pkg::apb_req_t APB_I, // apb
  input wire logic [31:0] PRDATA_O, // rdata
  input wire logic PREADY_O, // ready
  input wire logic PSLVERR_O, // error
  input cpu8_pkg::bus_req_t MEM_REQ_O, // bus cycle
  input wire logic [7:0] MEM_RDATA_I, // bus data
  input cpu8_pkg::dec_t DEC_O // decode
);
  import cpu8_pkg::*;
  logic act;
  cyc_t cyc;
  logic [15:0] ad;
  assign act = MEM_REQ_O.active;
  assign cyc = MEM_REQ_O.cyc;
  assign ad = MEM_REQ_O.addr;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_prog; act && cyc == CYC_PROG; endsequence
  sequence s_vec; act && cyc == CYC_VEC; endsequence
  sequence s_push; act && cyc == CYC_PUSH; endsequence
  a_free_read: assert property (act && cyc == CYC_FREE |-> !MEM_REQ_O.write)
    else $error("free cycle writes");
  a_fetch_next: assert property (s_prog ##1 s_prog |-> ad == $past(ad) + 16'h1)
    else $error("fetch skips");
  a_vec_page: assert property (s_vec |-> ad[15:8] == VEC_PAGE)
    else $error("vector page");
  a_vec_order: assert property (s_vec ##0 !ad[0] |=> s_vec ##0 ad == $past(ad) + 16'h1)
    else $error("vector order");
  a_push_write: assert property (s_push |-> MEM_REQ_O.write)
    else $error("push reads");
  a_push_down: assert property (s_push ##1 s_push |-> ad == $past(ad) - 16'h1)
    else $error("push address");
  a_rw_dir: assert property (act && cyc inside {CYC_READ, CYC_WRITE, CYC_POP}
    |-> MEM_REQ_O.write == (cyc == CYC_WRITE)) else $error("direction");
  a_cycle_sum: assert property (DEC_O.length != 3'h0
    |-> DEC_O.cycles == DEC_O.length + 4'h1 + DEC_O.seq_len) else $error("cycle count");
endmodule

//--- verif/tb_cpu8_opcode_bus_cycle_decoder.sv
// self-checking bench of the cpu8 decoder with a memory model
`timescale 1ns/10ps
module tb_cpu8_opcode_bus_cycle_decoder;
  import cpu8_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  apb_req_t apb = '0;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  bus_req_t req;
  logic [7:0] rdata;
  logic [31:0] d;
  logic e;
  int bad_count = 0;
  int n_checks = 0;
  // address above, byte in the low eight bits
  logic [23:0] img [22] = '{24'h0000C6, 24'h000112, 24'h000234, 24'h0003B7, 24'h000440,
    24'h000587, 24'h000686, 24'h000783, 24'h123480, 24'hFFFC20, 24'hFFFD00, 24'hFFFE00,
    24'hFFFF50, 24'h2000A0, 24'h200101, 24'h200220, 24'h2003FE, 24'h0050E6,
    24'h005102, 24'h00529E, 24'h0053E6, 24'h005401};
  cpu8_opcode_bus_cycle_decoder i_dut (.CLK_I(clk), .RESETN_I(rstn), .APB_I(apb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .MEM_REQ_O(req),
    .MEM_RDATA_I(rdata), .DEC_O());
  cpu8_mem_model i_mem (.clk_i(clk), .req_i(req), .rdata_o(rdata));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    d = prdata;
    e = perr;
    apb <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(d, exp);
  endtask
  // start through ctrl, poll busy; last status stays in d
  task automatic run(input logic [31:0] c);
    xfer(1'b1, OFS_CTRL, c);
    xfer(1'b0, OFS_STATUS, 32'h0);
    while (d[ST_BUSY_BIT] !== 1'b0) xfer(1'b0, OFS_STATUS, 32'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 65536; i++) i_mem.mem[i] = 8'h00;
    foreach (img[i]) i_mem.mem[img[i][23:8]] = img[i][7:0];
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_SP, 32'hFF);
    rd(OFS_FLAGS, 32'h68);
    xfer(1'b0, 8'h20, 32'h0);
    check({d[31:1], e}, 32'h1);
    $display("test reset done");
    run(32'h1);
    check(32'(d[19:8]), 32'h353);
    rd(OFS_ACC, 32'h80);
    rd(OFS_FLAGS, 32'h6C);
    run(32'h1);
    check(32'(i_mem.mem[16'h40]), 32'h80);
    run(32'h1);
    check(32'(i_mem.mem[16'hFF]), 32'h80);
    rd(OFS_SP, 32'hFE);
    run(32'h1);
    rd(OFS_SP, 32'hFF);
    $display("test load store stack done");
    run(32'h1);
    check(32'(i_mem.mem[16'hFF]), 32'h08);
    rd(OFS_PC, 32'h2000);
    run(32'h1);
    rd(OFS_ACC, 32'h7F);
    rd(OFS_FLAGS, 32'hE8);
    run(32'h1);
    rd(OFS_PC, 32'h2002);
    run(32'h4);
    rd(OFS_PC, 32'h50);
    $display("test swi branch vector done");
    run(32'h1);
    rd(OFS_ACC, 32'h34);
    run(32'h1);
    check(32'(d[19:8]), 32'h853);
    rd(OFS_ACC, 32'h6C);
    // byte after the prefixed load is blank memory, an undefined opcode
    run(32'h1);
    check(d, 32'h3102);
    xfer(1'b1, OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h3100);
    $display("test offset modes illegal done");
    give_verdict();
  end
endmodule
bind cpu8_opcode_bus_cycle_decoder cpu8_decoder_chk i_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .APB_I(APB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .MEM_REQ_O(MEM_REQ_O), .MEM_RDATA_I(MEM_RDATA_I), .DEC_O(DEC_O));
